/* File: verilog/btg_pkg.sv */
package btg_pkg;

    // Register bus geometry
    localparam int ADDR_W = 20;
    localparam int IDX_W  = ADDR_W - 2;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CLK  = 18'h0_506e;
    localparam logic [IDX_W-1:0] IDX_CTL  = 18'h0_5180;
    localparam logic [IDX_W-1:0] IDX_FREQ = 18'h0_5181;
    localparam logic [IDX_W-1:0] IDX_VOL  = 18'h0_5182;

    // Control register layout, reserved bits kept for position only
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic [1:0] time_sel;
        logic [1:0] mode;
        logic       rsv_lo;
        logic       run;
    } btg_ctl_t;

    localparam logic [7:0] CTL_RST  = 8'h00;
    localparam logic       GATE_RST = 1'h0;
    localparam logic [2:0] FREQ_RST = 3'h0;
    localparam logic [2:0] VOL_RST  = 3'h0;

    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_ONESHOT  = 2'h1;
    localparam logic [1:0] MODE_ENVELOPE = 2'h2;

    // Tone period and high time in oscillator clocks
    localparam logic [4:0] PER_16    = 5'h10;
    localparam logic [4:0] PER_20    = 5'h14;
    localparam logic [4:0] PER_24    = 5'h18;
    localparam logic [4:0] PER_28    = 5'h1c;
    localparam logic [4:0] HIGH_NARR = 5'h08;
    localparam logic [4:0] HIGH_WIDE = 5'h0c;
    localparam logic [2:0] LVL_MAX   = 3'h0;
    localparam logic [2:0] LVL_MIN   = 3'h7;

    // Shortest selectable duration; the others double it per code step
    localparam real TIME_BASE_MS = 15.63;
    localparam int  TMR_W        = 13;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : btg_pkg

/* File: verilog/btg_top.sv */
`timescale 1ns/1ns

// Overview of operation
// - Normal mode: run bit turns tone on/off
// - One-shot: run write starts timed burst
// - One-shot: run reads 1 until burst ends
// - One-shot: writing 0 stops tone immediately
// - One-shot: rewriting 1 restarts full duration
// - Envelope: start at max, step down per interval
// - Envelope: tone stops after level 6, before reaching minimum level 7
// - Envelope: run reads 1 until decay ends
// - Envelope: writing 0 stops tone immediately
// - Envelope: rewriting 1 restarts decay at max
// - 3-bit field, low two bits select four tone frequencies
// - 3-bit volume field, 0 max, 7 min
// - Period 16/20/24/28 oscillator clocks per frequency
// - Envelope ignores software volume field
// - Time select sets burst and step interval
// - Mode field: normal, one-shot, envelope, reserved
// - Clock gate closed means no output
module btg_top #(
    parameter int OSC_HZ = 32768
) (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic [btg_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [btg_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [btg_pkg::DATA_W/8-1:0]  s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [btg_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [btg_pkg::DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          low_speed_osc_clock,
    output logic                               tone_out
);
    import btg_pkg::*;

    // Rounded to whole oscillator clocks
    localparam int               BASE_TICKS = int'(TIME_BASE_MS * OSC_HZ / 1000.0);
    localparam logic [TMR_W-1:0] BASE_T     = TMR_W'(BASE_TICKS > 0 ? BASE_TICKS : 1);

    // Bus state
    logic                   aw_have_r,  aw_have_nxt;
    logic [IDX_W-1:0]       awidx_r,    awidx_nxt;
    logic                   w_have_r,   w_have_nxt;
    logic [7:0]             wbyte_r,    wbyte_nxt;
    logic                   wlane_r,    wlane_nxt;
    logic                   awready_r,  awready_nxt;
    logic                   wready_r,   wready_nxt;
    logic                   bvalid_r,   bvalid_nxt;
    logic [1:0]             bresp_r,    bresp_nxt;
    logic                   arready_r,  arready_nxt;
    logic                   rvalid_r,   rvalid_nxt;
    logic [1:0]             rresp_r,    rresp_nxt;
    logic [DATA_W-1:0]      rdata_r,    rdata_nxt;

    // Write strobe towards the core
    logic                   wr_en;
    logic [IDX_W-1:0]       wr_idx;
    logic [7:0]             wr_byte;

    // Core state
    logic                   gate_r,     gate_nxt;
    btg_ctl_t               ctl_r,      ctl_nxt;
    logic [2:0]             freq_r,     freq_nxt;
    logic [2:0]             vol_r,      vol_nxt;
    logic                   osc_s1_r,   osc_s1_nxt;
    logic                   osc_s2_r,   osc_s2_nxt;
    logic                   osc_s3_r,   osc_s3_nxt;
    logic [4:0]             phase_r,    phase_nxt;
    logic [TMR_W-1:0]       tmr_r,      tmr_nxt;
    logic [2:0]             env_r,      env_nxt;
    logic                   tone_r,     tone_nxt;

    function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
        is_mapped = (idx == IDX_CLK) || (idx == IDX_CTL) ||
                    (idx == IDX_FREQ) || (idx == IDX_VOL);
    endfunction : is_mapped

    function automatic logic [7:0] rd_byte(input logic [IDX_W-1:0] idx);
        rd_byte = 8'h00;
        case (idx)
            IDX_CLK:  rd_byte = {7'h00, gate_r};
            IDX_CTL:  rd_byte = {2'h0, ctl_r.time_sel, ctl_r.mode, 1'h0, ctl_r.run};
            IDX_FREQ: rd_byte = {5'h00, freq_r};
            IDX_VOL:  rd_byte = {5'h00, vol_r};
            default:  rd_byte = 8'h00;
        endcase
    endfunction : rd_byte

    // AXI4-Lite slave
    always_comb begin
        logic aw_fire;
        logic w_fire;
        logic aw_ok;
        logic w_ok;
        logic do_wr;
        logic wlane;
        aw_fire     = s_axi_awvalid & awready_r;
        w_fire      = s_axi_wvalid & wready_r;
        aw_ok       = aw_have_r | aw_fire;
        w_ok        = w_have_r | w_fire;
        do_wr       = aw_ok & w_ok;
        wr_idx      = aw_have_r ? awidx_r : s_axi_awaddr[ADDR_W-1:2];
        wr_byte     = w_have_r ? wbyte_r : s_axi_wdata[7:0];
        wlane       = w_have_r ? wlane_r : s_axi_wstrb[0];
        wr_en       = do_wr & wlane & is_mapped(wr_idx);

        aw_have_nxt = aw_ok & ~do_wr;
        awidx_nxt   = aw_fire ? s_axi_awaddr[ADDR_W-1:2] : awidx_r;
        w_have_nxt  = w_ok & ~do_wr;
        wbyte_nxt   = w_fire ? s_axi_wdata[7:0] : wbyte_r;
        wlane_nxt   = w_fire ? s_axi_wstrb[0] : wlane_r;
        bvalid_nxt  = do_wr | (bvalid_r & ~s_axi_bready);
        bresp_nxt   = bresp_r;
        if (do_wr) begin
            bresp_nxt = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
        end
        // Single write in flight keeps the response ordering trivial
        awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
        wready_nxt  = ~w_have_nxt & ~bvalid_nxt;

        rvalid_nxt  = (s_axi_arvalid & arready_r) | (rvalid_r & ~s_axi_rready);
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (s_axi_arvalid & arready_r) begin
            rdata_nxt = {24'h00_0000, rd_byte(s_axi_araddr[ADDR_W-1:2])};
            rresp_nxt = is_mapped(s_axi_araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end
        arready_nxt = ~rvalid_nxt;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_have_r <= 1'h0;
            awidx_r   <= '0;
            w_have_r  <= 1'h0;
            wbyte_r   <= 8'h00;
            wlane_r   <= 1'h0;
            awready_r <= 1'h0;
            wready_r  <= 1'h0;
            bvalid_r  <= 1'h0;
            bresp_r   <= RESP_OKAY;
            arready_r <= 1'h0;
            rvalid_r  <= 1'h0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= '0;
        end else begin
            aw_have_r <= aw_have_nxt;
            awidx_r   <= awidx_nxt;
            w_have_r  <= w_have_nxt;
            wbyte_r   <= wbyte_nxt;
            wlane_r   <= wlane_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // Tone core
    always_comb begin
        logic             tick;
        logic             timed;
        logic             expire;
        logic             start;
        logic             stop;
        logic [4:0]       period;
        logic [4:0]       high;
        logic [2:0]       level;
        logic [TMR_W-1:0] interval;
        period     = PER_16;
        high       = HIGH_NARR;
        level      = LVL_MAX;
        start      = 1'h0;
        stop       = 1'h0;
        expire     = 1'h0;
        osc_s1_nxt = low_speed_osc_clock;
        osc_s2_nxt = osc_s1_r;
        osc_s3_nxt = osc_s2_r;
        // Gate closed: no oscillator edges reach the tone logic
        tick       = gate_r & osc_s2_r & ~osc_s3_r;
        timed      = (ctl_r.mode == MODE_ONESHOT) || (ctl_r.mode == MODE_ENVELOPE);
        interval   = BASE_T << ctl_r.time_sel;

        case (freq_r[1:0])
            2'h0:    period = PER_16;
            2'h1:    period = PER_20;
            2'h2:    period = PER_24;
            default: period = PER_28;
        endcase
        level = (ctl_r.mode == MODE_ENVELOPE) ? env_r : vol_r;
        high  = (freq_r[1] ? HIGH_WIDE : HIGH_NARR) - {2'h0, level};

        gate_nxt  = gate_r;
        ctl_nxt   = ctl_r;
        freq_nxt  = freq_r;
        vol_nxt   = vol_r;
        phase_nxt = phase_r;
        tmr_nxt   = tmr_r;
        env_nxt   = env_r;

        if (tick && ctl_r.run) begin
            phase_nxt = (phase_r >= period - 5'h01) ? 5'h00 : phase_r + 5'h01;
            if (timed) begin
                expire  = (tmr_r >= interval - 1'b1);
                tmr_nxt = expire ? '0 : tmr_r + 1'b1;
            end
        end
        if (expire) begin
            if (ctl_r.mode == MODE_ONESHOT) begin
                ctl_nxt.run = 1'h0;
            end else if (env_r == LVL_MIN - 3'h1) begin
                ctl_nxt.run = 1'h0;
            end else begin
                env_nxt = env_r + 3'h1;
            end
        end

        start = wr_en && (wr_idx == IDX_CTL) && wr_byte[0];
        stop  = wr_en && (wr_idx == IDX_CTL) && !wr_byte[0];
        if (wr_en) begin
            case (wr_idx)
                IDX_CLK:  gate_nxt = wr_byte[0];
                IDX_CTL:  begin
                    ctl_nxt.time_sel = wr_byte[5:4];
                    ctl_nxt.mode     = wr_byte[3:2];
                end
                IDX_FREQ: freq_nxt = wr_byte[2:0];
                IDX_VOL:  vol_nxt  = wr_byte[2:0];
                default:  gate_nxt = gate_r;
            endcase
        end
        // Software write beats a same-cycle hardware clear
        if (start) begin
            ctl_nxt.run = 1'h1;
            tmr_nxt     = '0;
            env_nxt     = LVL_MAX;
            phase_nxt   = 5'h00;
        end else if (stop) begin
            ctl_nxt.run = 1'h0;
        end
        if (!ctl_nxt.run) begin
            phase_nxt = 5'h00;
            tmr_nxt   = '0;
        end
        ctl_nxt.rsv_hi = 2'h0;
        ctl_nxt.rsv_lo = 1'h0;

        // Reserved mode keeps the pin quiet
        tone_nxt = gate_r && ctl_nxt.run && (ctl_nxt.mode != 2'h3) &&
                   (phase_nxt < high);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gate_r   <= GATE_RST;
            ctl_r    <= btg_ctl_t'(CTL_RST);
            freq_r   <= FREQ_RST;
            vol_r    <= VOL_RST;
            osc_s1_r <= 1'h0;
            osc_s2_r <= 1'h0;
            osc_s3_r <= 1'h0;
            phase_r  <= 5'h00;
            tmr_r    <= '0;
            env_r    <= LVL_MAX;
            tone_r   <= 1'h0;
        end else begin
            gate_r   <= gate_nxt;
            ctl_r    <= ctl_nxt;
            freq_r   <= freq_nxt;
            vol_r    <= vol_nxt;
            osc_s1_r <= osc_s1_nxt;
            osc_s2_r <= osc_s2_nxt;
            osc_s3_r <= osc_s3_nxt;
            phase_r  <= phase_nxt;
            tmr_r    <= tmr_nxt;
            env_r    <= env_nxt;
            tone_r   <= tone_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign tone_out      = tone_r;

endmodule : btg_top

/* File: verilog/btg_unused_none.sv */
`timescale 1ns/1ns

/* File: test/btg_top_sva.sv */
`timescale 1ns/1ns
module btg_top_sva (
    input wire logic                         clk,
    input wire logic                         reset,
    input wire logic [btg_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input wire logic                         s_axi_awvalid,
    input wire logic                         s_axi_awready,
    input wire logic [btg_pkg::DATA_W-1:0]   s_axi_wdata,
    input wire logic [btg_pkg::DATA_W/8-1:0] s_axi_wstrb,
    input wire logic                         s_axi_wvalid,
    input wire logic                         s_axi_wready,
    input wire logic [1:0]                   s_axi_bresp,
    input wire logic                         s_axi_bvalid,
    input wire logic                         s_axi_bready,
    input wire logic                         s_axi_arvalid,
    input wire logic                         s_axi_arready,
    input wire logic [btg_pkg::DATA_W-1:0]   s_axi_rdata,
    input wire logic                         s_axi_rvalid,
    input wire logic                         s_axi_rready,
    input wire logic                         tone_out
);
    import btg_pkg::*;
    logic gate_r, gate_nxt, gate_q_r;
    wire  wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // Shadow of the gate; only same-edge address and data writes are tracked
    always_comb begin
        gate_nxt = gate_r;
        if (wr_hs && s_axi_wstrb[0] && s_axi_awaddr[19:2] == IDX_CLK) begin
            gate_nxt = s_axi_wdata[0];
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gate_r   <= GATE_RST;
            gate_q_r <= GATE_RST;
        end else begin
            gate_r   <= gate_nxt;
            gate_q_r <= gate_r;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_ctl_wr;
        wr_hs && s_axi_wstrb[0] && s_axi_awaddr[19:2] == IDX_CTL;
    endsequence
    sequence s_run_on;
        s_ctl_wr ##0 (s_axi_wdata[0] && s_axi_wdata[3:2] != 2'h3 && gate_r);
    endsequence
    sequence s_run_off;
        s_ctl_wr ##0 !s_axi_wdata[0];
    endsequence
    AST_B_LAT: assert property (wr_hs |=> s_axi_bvalid)
        else $error("write response not one cycle after transfer");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted during read data");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during write response");
    AST_RSV_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    AST_TONE_ON: assert property (s_run_on |=> tone_out)
        else $error("tone did not start after run write");
    AST_TONE_OFF: assert property (s_run_off |=> !tone_out [*3])
        else $error("tone not stopped after run clear");
    AST_GATE_OFF: assert property (!gate_r && !gate_q_r |-> !tone_out)
        else $error("tone while clock gate closed");
endmodule : btg_top_sva

/* File: test/btg_sounder.sv */
`timescale 1ns/1ns
module btg_sounder (
    input wire logic clk,
    input wire logic tone_out,
    output int       hi_w,
    output int       per_w,
    output int       rises
);
    int   t_per = 0;
    int   t_hi  = 0;
    logic last  = 1'b0;
    initial begin
        hi_w  = 0;
        per_w = 0;
        rises = 0;
    end
    // Widths in system clocks; first pulse after a start is not tick aligned
    always @(posedge clk) begin
        t_per <= (tone_out && !last) ? 1 : t_per + 1;
        t_hi  <= (tone_out && !last) ? 1 : t_hi + 1;
        if (tone_out && !last) begin
            per_w <= t_per;
            rises <= rises + 1;
        end
        if (!tone_out && last) begin
            hi_w <= t_hi;
        end
        last <= tone_out;
    end
endmodule : btg_sounder

/* File: test/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import btg_pkg::*;
    localparam int OC   = 10;
    localparam int BASE = 4;
    logic        clk, reset, low_speed_osc_clock, tone_out;
    logic [19:0] s_axi_awaddr, s_axi_araddr, ra[4];
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          hi_w, per_w, rises, failures, n_tests, m_reg[4], mk[4], f, v, p, r0, k;
    time         t0;
    btg_top #(.OSC_HZ(256)) i_dut (.*);
    btg_sounder i_snd (.clk(clk), .tone_out(tone_out), .hi_w(hi_w), .per_w(per_w),
                       .rises(rises));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        low_speed_osc_clock = 0;
        forever #50 low_speed_osc_clock = ~low_speed_osc_clock;
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic hang;
        failures++;
        $display("CHECK FAILED wait expected done seen timeout");
        complete_run();
    endtask : hang
    // Starts one edge late so a release and a new request never share a step
    task automatic bus(input bit wr, input logic [19:0] a, input logic [31:0] d);
        bit got;
        int j;
        int hold;
        got  = 0;
        hold = $urandom % 3;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid  <= wr;
        s_axi_arvalid <= !wr;
        for (j = 0; j < 40 && !got; j++) begin
            @(posedge clk);
            // Late ready makes the slave hold its answer for a while
            if (j == hold) begin
                s_axi_bready <= wr;
                s_axi_rready <= !wr;
            end
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_bvalid && s_axi_bready) begin
                got = 1;
                rs  = s_axi_bresp;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                got = 1;
                rs  = s_axi_rresp;
                rd  = s_axi_rdata;
            end
        end
        s_axi_bready <= 0;
        s_axi_rready <= 0;
        if (!got) hang();
    endtask : bus
    task automatic wreg(input int i, input int d);
        bus(1, ra[i], d);
        chk("bresp", RESP_OKAY, rs);
        m_reg[i] = d & mk[i];
    endtask : wreg
    task automatic rreg(input int i);
        bus(0, ra[i], 0);
        chk("rresp", RESP_OKAY, rs);
        chk("rdata", m_reg[i], rd);
    endtask : rreg
    task automatic wait_rises(input int n);
        @(posedge clk);
        r0 = rises;
        for (k = 0; k < 3000 && rises < r0 + n; k++) @(posedge clk);
        if (rises < r0 + n) hang();
    endtask : wait_rises
    // A start between ticks may end up to one tick early; polling runs late
    task automatic wait_idle(input time ts, input int e);
        int j, d;
        for (j = 0; j < 1000; j++) begin
            bus(0, ra[1], 0);
            if (rd[0] === 1'b0) break;
        end
        if (j == 1000) hang();
        d = int'(($time - ts) / 10);
        chk("duration", e, (d >= e - OC && d <= e + 20) ? e : d);
        m_reg[1] = m_reg[1] & 32'h0000_003c;
        rreg(1);
        chk("tone", 0, tone_out);
        $display("burst of %0d cycles done", e);
    endtask : wait_idle
    initial begin
        void'($urandom(32'hcd20));
        {failures, n_tests} = 0;
        m_reg = '{0, 0, 0, 0};
        mk    = '{32'h0000_0001, 32'h0000_003d, 32'h0000_0007, 32'h0000_0007};
        ra    = '{{IDX_CLK, 2'h0}, {IDX_CTL, 2'h0}, {IDX_FREQ, 2'h0}, {IDX_VOL, 2'h0}};
        reset = 1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = 0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge clk);
        reset <= 0;
        for (f = 0; f < 4; f++) rreg(f);
        bus(1, 20'h0_0100, 32'h0000_00ff);
        chk("bresp", RESP_SLVERR, rs);
        bus(0, 20'h0_0100, 0);
        chk("rresp", RESP_SLVERR, rs);
        chk("rdata", 0, rd);
        for (f = 0; f < 4; f++) begin
            wreg(f, 32'h0000_00fe);
            rreg(f);
        end
        $display("register test done");
        for (f = 0; f < 2; f++) begin
            wreg(0, f);
            wreg(1, f ? 32'h0000_000d : 32'h0000_0001);
            r0 = rises;
            repeat (400) @(posedge clk);
            chk("rises", r0, rises);
            wreg(1, 0);
        end
        $display("silent test done");
        for (f = 0; f < 8; f++) begin
            v = $urandom % 8;
            p = 16 + 4 * (f % 4);
            wreg(2, f);
            wreg(3, v);
            wreg(1, (($urandom % 4) << 4) | 1);
            wait_rises(2);
            chk("period", p * OC, per_w);
            chk("high", ((f % 4 >= 2) ? 12 - v : 8 - v) * OC, hi_w);
            wreg(1, 0);
        end
        $display("normal test done");
        wreg(2, 0);
        for (f = 0; f < 4; f++) begin
            wreg(1, (f << 4) | 5);
            t0 = $time;
            rreg(1);
            wait_idle(t0, (BASE << f) * OC);
        end
        wreg(1, 32'h0000_0025);
        repeat (100) @(posedge clk);
        wreg(1, 32'h0000_0025);
        t0 = $time;
        wait_idle(t0, 4 * BASE * OC);
        wreg(1, 32'h0000_0025);
        repeat (30) @(posedge clk);
        wreg(1, 32'h0000_0024);
        rreg(1);
        chk("tone", 0, tone_out);
        wreg(3, 7);
        wreg(1, 32'h0000_0039);
        repeat (500) @(posedge clk);
        wreg(1, 32'h0000_0039);
        t0 = $time;
        wait_rises(2);
        chk("high", 8 * OC, hi_w);
        while ($time - t0 < (6 * 8 * BASE + 22) * OC * 10) @(posedge clk);
        chk("high", 2 * OC, hi_w);
        wait_idle(t0, 7 * 8 * BASE * OC);
        wreg(1, 32'h0000_0039);
        repeat (100) @(posedge clk);
        wreg(1, 32'h0000_0038);
        rreg(1);
        chk("tone", 0, tone_out);
        $display("envelope test done");
        complete_run();
    end
endmodule : testbench
bind btg_top btg_top_sva i_sva (.*);
